// ===== logic/sbr_core.sv
// Serial peripheral controller with programmable baud divider, AXI4-Lite regs.
// Assumes pins arrive asynchronously and the wire level is resolved outside.
module sbr_core
   import sbr_pkg::*;
#(
   parameter int AW = 5                     // Byte address width
)(
   input  wire logic          clock,        // 20 MHz bus clock
   input  wire logic          reset,        // Async, active high
   input  wire logic          awvalid,      // Write address valid
   output logic               awready,      // Write address ready
   input  wire logic [AW-1:0] awaddr,       // Write byte address
   input  wire logic          wvalid,       // Write data valid
   output logic               wready,       // Write data ready
   input  wire logic [31:0]   wdata,        // Write data
   input  wire logic [3:0]    wstrb,        // Byte enables
   output logic               bvalid,       // Write response valid
   input  wire logic          bready,       // Write response ready
   output logic [1:0]         bresp,        // Write response code
   input  wire logic          arvalid,      // Read address valid
   output logic               arready,      // Read address ready
   input  wire logic [AW-1:0] araddr,       // Read byte address
   output logic               rvalid,       // Read data valid
   input  wire logic          rready,       // Read data ready
   output logic [31:0]        rdata,        // Read data
   output logic [1:0]         rresp,        // Read response code
   input  wire sbr_pin_in_s   pinIn,        // Pin levels
   output sbr_pin_out_s       pinOut        // Pin drives and enables
);

   logic [7:0]    ctrl_reg, baud_reg;
   logic [15:0]   txData_reg, rxData_reg, shift_reg, rxSh_reg;
   logic          txFull_reg, done_reg, awHeld_reg, wHeld_reg;
   logic [2:0]    awIdx_reg;
   logic [31:0]   wData_reg;
   logic [3:0]    wStrb_reg;
   sbr_state_e    state_reg;
   logic [10:0]   cnt_reg, half_reg;
   logic [4:0]    edgeCnt_reg;
   logic          sck_reg, ssN_reg;
   logic [2:0]    sckSync_reg;
   logic [1:0]    ssSync_reg, mosiSync_reg, misoSync_reg;

   logic          enable, master, phase, pol, wide, tick, slvSel, slvEdge;
   logic          edgeNow, leadEdge, sampleNow, shiftNow, lastEdge, bitIn;
   logic          wrFire, baudChg, abort, doneSet;
   logic [15:0]   txWord;

   assign enable    = ctrl_reg[SBR_C_EN];
   assign master    = ctrl_reg[SBR_C_MSTR];
   assign phase     = ctrl_reg[SBR_C_PHASE];
   assign pol       = ctrl_reg[SBR_C_POL];
   assign wide      = ctrl_reg[SBR_C_WIDE];
   assign wrFire    = awHeld_reg && wHeld_reg && !bvalid;

   // Edge timing: master from half-period divider, slave from synced pin
   assign tick      = (cnt_reg == 11'h001);
   assign slvSel    = enable && !master && !ssSync_reg[1];
   assign slvEdge   = slvSel && (sckSync_reg[2] != sckSync_reg[1])
                      && (state_reg == SBR_IDLE || state_reg == SBR_TAIL);
   assign edgeNow   = master ? (state_reg == SBR_SHIFT && tick) : slvEdge;
   assign leadEdge  = master ? !edgeCnt_reg[0] : (sckSync_reg[1] != pol);
   assign sampleNow = edgeNow && (leadEdge ^ phase);
   // Phase one puts the first bit out early, so its first shift is skipped
   assign shiftNow  = edgeNow && (leadEdge == phase) && !(phase && edgeCnt_reg == 5'h00);
   assign lastEdge  = edgeCnt_reg == (wide ? SBR_LAST_WIDE : SBR_LAST_NARROW);
   assign bitIn     = master ? misoSync_reg[1] : mosiSync_reg[1];
   assign txWord    = wide ? txData_reg : {txData_reg[7:0], 8'h00};

   // Any change of the divider fields in master mode kills the transfer
   assign baudChg   = wrFire && awIdx_reg == SBR_IDX_BAUD && wStrb_reg[0]
                      && ((wData_reg[7:0] & SBR_BAUD_MASK) != baud_reg);
   assign abort     = master && baudChg;
   // Done lands when the half period after the last edge has run out
   assign doneSet   = enable && state_reg == SBR_TAIL && (tick || slvEdge);

   // Two-stage synchronisers; third sck stage only feeds edge detection
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         sckSync_reg  <= 3'h0;
         ssSync_reg   <= 2'h3;
         mosiSync_reg <= 2'h0;
         misoSync_reg <= 2'h0;
      end
      else
      begin
         sckSync_reg  <= {sckSync_reg[1:0], pinIn.sck};
         ssSync_reg   <= {ssSync_reg[0], pinIn.ssN};
         mosiSync_reg <= {mosiSync_reg[0], pinIn.mosi};
         misoSync_reg <= {misoSync_reg[0], pinIn.miso};
      end
   end

   // Write channel: address and data taken in either order
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         awready    <= 1'b1;
         wready     <= 1'b1;
         awHeld_reg <= 1'b0;
         wHeld_reg  <= 1'b0;
         awIdx_reg  <= 3'h0;
         wData_reg  <= 32'h0000_0000;
         wStrb_reg  <= 4'h0;
         bvalid     <= 1'b0;
         bresp      <= SBR_RESP_OK;
      end
      else
      begin
         if (awvalid && awready)
         begin
            awHeld_reg <= 1'b1;
            awready    <= 1'b0;
            awIdx_reg  <= (awaddr[1:0] == 2'h0) ? awaddr[4:2] : 3'h7;
         end
         if (wvalid && wready)
         begin
            wHeld_reg <= 1'b1;
            wready    <= 1'b0;
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
         end
         if (wrFire)
         begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            bvalid     <= 1'b1;
            bresp      <= (awIdx_reg == SBR_IDX_CTRL || awIdx_reg == SBR_IDX_BAUD ||
                           awIdx_reg == SBR_IDX_STAT || awIdx_reg == SBR_IDX_DATA)
                          ? SBR_RESP_OK : SBR_RESP_DEC;
         end
         if (bvalid && bready)
         begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Software registers; hardware sets of flags win over clears
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         ctrl_reg   <= SBR_CTRL_RST;
         baud_reg   <= SBR_BAUD_RST;
         txData_reg <= 16'h0000;
         txFull_reg <= 1'b0;
         done_reg   <= 1'b0;
         rxData_reg <= 16'h0000;
      end
      else
      begin
         if (wrFire && wStrb_reg[0] && awIdx_reg == SBR_IDX_CTRL)
            ctrl_reg <= wData_reg[7:0] & SBR_CTRL_MASK;
         // Reserved bits masked so they never change
         if (wrFire && wStrb_reg[0] && awIdx_reg == SBR_IDX_BAUD)
            baud_reg <= wData_reg[7:0] & SBR_BAUD_MASK;
         if ((state_reg == SBR_IDLE && enable && master) || doneSet)
            txFull_reg <= 1'b0;
         if (wrFire && awIdx_reg == SBR_IDX_DATA && wStrb_reg[1:0] != 2'h0)
         begin
            txFull_reg <= 1'b1;
            if (wStrb_reg[0])
               txData_reg[7:0] <= wData_reg[7:0];
            if (wStrb_reg[1])
               txData_reg[15:8] <= wData_reg[15:8];
         end
         if (wrFire && wStrb_reg[0] && awIdx_reg == SBR_IDX_STAT && wData_reg[SBR_S_DONE])
            done_reg <= 1'b0;
         if (doneSet)
         begin
            done_reg   <= 1'b1;
            rxData_reg <= wide ? rxSh_reg : {8'h00, rxSh_reg[7:0]};
         end
      end
   end

   // Read channel: one-cycle answer, unmapped words read zero
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= SBR_RESP_OK;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= SBR_RESP_OK;
         rdata   <= 32'h0000_0000;
         case ((araddr[1:0] == 2'h0) ? araddr[4:2] : 3'h7)
            SBR_IDX_CTRL: rdata[7:0] <= ctrl_reg;
            SBR_IDX_BAUD: rdata[7:0] <= baud_reg;
            SBR_IDX_STAT: rdata[7:0] <= {done_reg, 1'b0, !txFull_reg, 4'h0,
                                         state_reg != SBR_IDLE};
            SBR_IDX_DATA: rdata[15:0] <= rxData_reg;
            default:      rresp <= SBR_RESP_DEC;
         endcase
      end
      else if (rvalid && rready)
      begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Transfer engine shared by master and slave
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state_reg   <= SBR_IDLE;
         cnt_reg     <= 11'h000;
         half_reg    <= 11'h001;
         edgeCnt_reg <= 5'h00;
         shift_reg   <= 16'h0000;
         rxSh_reg    <= 16'h0000;
         sck_reg     <= 1'b0;
         ssN_reg     <= 1'b1;
      end
      else if (!enable || abort)
      begin
         state_reg   <= SBR_IDLE;
         ssN_reg     <= 1'b1;
         sck_reg     <= pol;
         edgeCnt_reg <= 5'h00;
      end
      else
      begin
         if (state_reg == SBR_IDLE)
            cnt_reg <= sbrHalf(baud_reg);
         else if (tick)
            cnt_reg <= half_reg;
         else
            cnt_reg <= cnt_reg - 11'h001;
         if (sampleNow)
            rxSh_reg <= {rxSh_reg[14:0], bitIn};
         if (shiftNow)
            shift_reg <= {shift_reg[14:0], 1'b0};
         if (edgeNow)
         begin
            edgeCnt_reg <= lastEdge ? 5'h00 : edgeCnt_reg + 5'h01;
            if (master)
               sck_reg <= !sck_reg;
         end
         // Deselected slave restarts its bit count
         if (!master && ssSync_reg[1] && state_reg == SBR_IDLE)
            edgeCnt_reg <= 5'h00;
         case (state_reg)
            SBR_IDLE:
            begin
               half_reg <= sbrHalf(baud_reg);
               sck_reg  <= pol;
               if (master && txFull_reg)
               begin
                  shift_reg <= txWord;
                  ssN_reg   <= 1'b0;
                  state_reg <= SBR_LEAD;
               end
               else if (!master && edgeCnt_reg == 5'h00 && !slvEdge)
                  shift_reg <= txWord;
               else if (!master && slvEdge && lastEdge)
               begin
                  state_reg <= SBR_TAIL;
                  cnt_reg   <= half_reg;
               end
            end
            SBR_LEAD:
               if (tick)
                  state_reg <= SBR_SHIFT;
            SBR_SHIFT:
               if (tick && lastEdge)
                  state_reg <= SBR_TAIL;
            SBR_TAIL:
               if (master && tick && txFull_reg)
               begin
                  // Select stays low and the lead is skipped
                  shift_reg <= txWord;
                  state_reg <= SBR_SHIFT;
               end
               else if (master && tick)
               begin
                  ssN_reg   <= 1'b1;
                  state_reg <= SBR_GAP;
               end
               else if (!master)
               begin
                  if (!slvEdge)
                     shift_reg <= txWord;
                  if (doneSet)
                     state_reg <= SBR_IDLE;
               end
            SBR_GAP:
               if (tick)
                  state_reg <= SBR_IDLE;
            default:
               state_reg <= SBR_IDLE;
         endcase
      end
   end

   // Pin drivers registered so every output leaves a flip-flop
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         pinOut <= '{sck: 1'b0, sckOe: 1'b0, ssN: 1'b1, ssNOe: 1'b0,
                     mosi: 1'b0, mosiOe: 1'b0, miso: 1'b0, misoOe: 1'b0};
      else
         pinOut <= '{sck: sck_reg, sckOe: enable && master,
                     ssN: ssN_reg, ssNOe: enable && master,
                     mosi: shift_reg[15], mosiOe: enable && master,
                     miso: shift_reg[15], misoOe: slvSel};
   end

   sequence tailTick;
      master && state_reg == SBR_TAIL && tick;
   endsequence

   sequence restartNoGap;
      state_reg == SBR_SHIFT && !ssN_reg;
   endsequence

   abort_idle_a: assert property (@(posedge clock) disable iff (reset)
      abort |=> state_reg == SBR_IDLE && ssN_reg)
      else $error("divider change did not abort");
   sck_toggle_a: assert property (@(posedge clock) disable iff (reset)
      enable && master && state_reg == SBR_SHIFT && tick && !abort |=> sck_reg != $past(sck_reg))
      else $error("serial clock missed its half period");
   done_time_a: assert property (@(posedge clock) disable iff (reset)
      tailTick |=> done_reg)
      else $error("done flag late after last edge");
   b2b_go_a: assert property (@(posedge clock) disable iff (reset)
      tailTick and txFull_reg && enable && !abort |=> restartNoGap)
      else $error("waiting data not sent at once");
   gap_high_a: assert property (@(posedge clock) disable iff (reset)
      state_reg == SBR_GAP |-> ssN_reg && sck_reg == pol)
      else $error("select low during idle gap");
   lead_quiet_a: assert property (@(posedge clock) disable iff (reset)
      state_reg == SBR_LEAD |-> !ssN_reg && sck_reg == pol)
      else $error("clock moved during leading delay");
   baud_resv_a: assert property (@(posedge clock) disable iff (reset)
      (baud_reg & ~SBR_BAUD_MASK) == 8'h00)
      else $error("reserved divider bits changed");
   div_hold_a: assert property (@(posedge clock) disable iff (reset)
      state_reg != SBR_IDLE && $past(state_reg) != SBR_IDLE |-> $stable(half_reg))
      else $error("divider changed mid transfer");
   wide_end_a: assert property (@(posedge clock) disable iff (reset)
      master && state_reg == SBR_SHIFT && tick && !abort && edgeCnt_reg == SBR_LAST_WIDE
      |-> wide ##1 state_reg == SBR_TAIL)
      else $error("wide transfer edge count wrong");

endmodule

// ===== logic/sbr_pkg.sv
// Constants, pin carriers and divisor arithmetic for the serial baud block.
// Assumes a single bus clock and an AXI4-Lite register port.
package sbr_pkg;

   // Register word indices; byte address is four times the index
   localparam logic [2:0] SBR_IDX_CTRL = 3'h0;
   localparam logic [2:0] SBR_IDX_BAUD = 3'h2;
   localparam logic [2:0] SBR_IDX_STAT = 3'h3;
   localparam logic [2:0] SBR_IDX_DATA = 3'h4;

   // Reset values and writable masks
   localparam logic [7:0] SBR_CTRL_RST  = 8'h00;
   localparam logic [7:0] SBR_CTRL_MASK = 8'h1F;
   localparam logic [7:0] SBR_BAUD_RST  = 8'h00;
   localparam logic [7:0] SBR_BAUD_MASK = 8'h77;

   // Field positions
   localparam int SBR_PRE_LSB  = 4;
   localparam int SBR_RATE_LSB = 0;
   localparam int SBR_C_EN     = 0;
   localparam int SBR_C_MSTR   = 1;
   localparam int SBR_C_PHASE  = 2;
   localparam int SBR_C_POL    = 3;
   localparam int SBR_C_WIDE   = 4;
   localparam int SBR_S_DONE   = 7;
   localparam int SBR_S_TXE    = 5;
   localparam int SBR_S_BUSY   = 0;

   // Edge counts per transfer, less one
   localparam logic [4:0] SBR_LAST_NARROW = 5'h0F;
   localparam logic [4:0] SBR_LAST_WIDE   = 5'h1F;

   localparam logic [1:0] SBR_RESP_OK  = 2'h0;
   localparam logic [1:0] SBR_RESP_DEC = 2'h3;

   typedef enum logic [2:0] {
      SBR_IDLE  = 3'b000,
      SBR_LEAD  = 3'b001,
      SBR_SHIFT = 3'b010,
      SBR_TAIL  = 3'b011,
      SBR_GAP   = 3'b100
   } sbr_state_e;

   typedef struct packed {
      logic sck;
      logic ssN;
      logic mosi;
      logic miso;
   } sbr_pin_in_s;

   typedef struct packed {
      logic sck;
      logic sckOe;
      logic ssN;
      logic ssNOe;
      logic mosi;
      logic mosiOe;
      logic miso;
      logic misoOe;
   } sbr_pin_out_s;

   // Half serial period in bus clocks: (pre+1) * 2^rate, divisor is twice that
   function automatic logic [10:0] sbrHalf(input logic [7:0] baud);
      logic [10:0] pre;
      pre = {8'h00, baud[SBR_PRE_LSB+:3]} + 11'h001;
      return pre << baud[SBR_RATE_LSB+:3];
   endfunction

endpackage

// ===== verification/sbr_slave_model.sv
// Behavioural serial slave standing on the far side of the pins.
// Assumes clock polarity zero; phase chosen by the bench, reply is fixed.
module sbr_slave_model
(
   input  wire logic        sck,      // Serial clock from the master
   input  wire logic        ssN,      // Select, active low
   input  wire logic        mosi,     // Data from the master
   input  wire logic        phase,    // Clock phase in use
   output logic             miso,     // Data to the master
   output logic [15:0]      rxWord,   // Bits taken, last sixteen
   output int               bitCount  // Bits taken since select fell
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [15:0] txReg;

   initial
   begin
      miso = 1'b0;
      rxWord = 16'h0000;
      bitCount = 0;
      txReg = 16'hA55A;
   end

   // New frame; phase zero shows its first bit at select
   always @(negedge ssN)
   begin
      txReg = 16'hA55A;
      bitCount = 0;
      rxWord = 16'h0000;
      if (!phase)
         miso = txReg[15];
   end

   // Released line has no pull, so show a stale inverse, not the last bit
   always @(posedge ssN)
      miso = ~miso;

   // Count carries on while select stays low between frames
   always @(posedge sck)
      if (!ssN)
      begin
         if (phase)
         begin
            miso = txReg[15];
            txReg = txReg << 1;
         end
         else
         begin
            rxWord = {rxWord[14:0], mosi};
            bitCount++;
         end
      end

   // Trailing edge: sample for phase one, shift out for phase zero
   always @(negedge sck)
      if (!ssN)
      begin
         if (phase)
         begin
            rxWord = {rxWord[14:0], mosi};
            bitCount++;
         end
         else
         begin
            txReg = txReg << 1;
            miso = txReg[15];
         end
      end
endmodule

// ===== verification/spi_baud_rate_generator_bench.sv
// Self-checking bench: register tasks over AXI4-Lite and transfer scenarios.
// Assumes the slave model on the pins and a 20 MHz bus clock.
module spi_baud_rate_generator_bench
   import sbr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic         clock, reset, awvalid, wvalid, bready, arvalid, rready;
   logic         awready, wready, bvalid, arready, rvalid;
   logic [4:0]   awaddr, araddr;
   logic [31:0]  wdata, rdata, rd;
   logic [3:0]   wstrb;
   logic [1:0]   bresp, rresp, rsp;
   sbr_pin_in_s  pinIn;
   sbr_pin_out_s pinOut;
   logic         slvMiso, slvPhase, prevSck, prevSs;
   logic [15:0]  slvRx;
   int           slvBits, nMismatch, totalChecks, cyc, lastEdge, edges;
   int           minGap, maxGap, ssRise, half, dly;
   logic [7:0]   bauds [5] = '{8'h00, 8'h07, 8'h10, 8'h11, 8'h73};

   // Wire levels; select reads high when nobody drives it
   assign pinIn = sbr_pin_in_s'{sck: pinOut.sckOe & pinOut.sck,
                                ssN: pinOut.ssNOe ? pinOut.ssN : 1'b1,
                                mosi: pinOut.mosiOe & pinOut.mosi,
                                miso: pinOut.misoOe ? pinOut.miso : slvMiso};

   sbr_core u_sbr_core (.clock(clock), .reset(reset), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .pinIn(pinIn), .pinOut(pinOut));

   sbr_slave_model u_sbr_slave_model (.sck(pinIn.sck), .ssN(pinIn.ssN), .mosi(pinIn.mosi),
      .phase(slvPhase), .miso(slvMiso), .rxWord(slvRx), .bitCount(slvBits));

   always #25 clock = ~clock;

   // Edge spacing and select releases seen at the pins, plus the hang limit
   always @(posedge clock)
   begin
      cyc++;
      if (pinOut.sck !== prevSck)
      begin
         if (edges > 0 && cyc - lastEdge < minGap)
            minGap = cyc - lastEdge;
         if (edges > 0 && cyc - lastEdge > maxGap)
            maxGap = cyc - lastEdge;
         edges++;
         lastEdge = cyc;
      end
      if (pinOut.ssN === 1'b1 && prevSs === 1'b0)
         ssRise++;
      prevSck = pinOut.sck;
      prevSs = pinOut.ssN;
      if (cyc == 30000)
      begin
         nMismatch++;
         stop_test();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         nMismatch++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // Address and data offered together, each released once taken
   task automatic axiWrite(input logic [2:0] idx, input logic [31:0] data);
      @(posedge clock);
      awaddr <= {idx, 2'b00};
      wdata <= data;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axiRead(input logic [2:0] idx);
      @(posedge clock);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (arvalid && arready)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask

   task automatic startMeasure();
      edges = 0;
      minGap = 99999;
      maxGap = 0;
      ssRise = 0;
   endtask

   // Polls busy; the first cycles are skipped so a launch is not missed
   task automatic waitIdle();
      repeat (4) @(posedge clock);
      do
         axiRead(SBR_IDX_STAT);
      while (rd[SBR_S_BUSY] !== 1'b0);
   endtask

   task automatic waitDone();
      do
         axiRead(SBR_IDX_STAT);
      while (rd[SBR_S_DONE] !== 1'b1);
      dly = cyc - lastEdge;
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      clock = 1'b0;
      reset = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, slvPhase} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = {10'h000, 32'h0000_0000, 4'hF};
      {nMismatch, totalChecks, cyc, edges, ssRise} = {5{32'h0000_0000}};
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      // Baud reset value, reserved bits and two unmapped places
      axiRead(SBR_IDX_BAUD);
      check("baud reset", rd, {24'h000000, SBR_BAUD_RST});
      axiWrite(SBR_IDX_BAUD, 32'h0000_00FF);
      axiRead(SBR_IDX_BAUD);
      check("baud reserved", rd, 32'h0000_0077);
      axiRead(3'h7);
      check("unmapped read", rsp, SBR_RESP_DEC);
      axiWrite(3'h5, 32'h0000_0001);
      check("unmapped write", rsp, SBR_RESP_DEC);
      axiWrite(SBR_IDX_CTRL, 32'h0000_0003);
      // Pin enables show up one cycle after the control write lands
      @(posedge clock);
      check("sck drive", pinOut.sckOe, 1'b1);
      check("miso drive", pinOut.misoOe, 1'b0);
      // Divisor sweep: spacing of every serial clock edge
      foreach (bauds[i])
      begin
         half = (int'(bauds[i][6:4]) + 1) << bauds[i][2:0];
         axiWrite(SBR_IDX_BAUD, {24'h000000, bauds[i]});
         startMeasure();
         axiWrite(SBR_IDX_DATA, 32'h0000_003C);
         waitDone();
         check("done early", 32'(dly + 1 >= half), 32'h1);
         check("done late", 32'(dly <= half + 10), 32'h1);
         waitIdle();
         check("edge count", edges, 32'h10);
         check("min half period", minGap, half);
         check("max half period", maxGap, half);
         check("slave byte", slvRx[7:0], 8'h3C);
         check("slave bits", slvBits, 32'h8);
         axiWrite(SBR_IDX_STAT, 32'h0000_0080);
      end
      // Divider change in mid-transfer
      axiWrite(SBR_IDX_BAUD, 32'h0000_0007);
      startMeasure();
      axiWrite(SBR_IDX_DATA, 32'h0000_0055);
      repeat (600) @(posedge clock);
      axiWrite(SBR_IDX_BAUD, 32'h0000_0006);
      repeat (3) @(posedge clock);
      check("select after abort", pinOut.ssN, 1'b1);
      axiRead(SBR_IDX_STAT);
      check("busy after abort", rd[SBR_S_BUSY], 1'b0);
      check("done after abort", rd[SBR_S_DONE], 1'b0);
      check("empty after abort", rd[SBR_S_TXE], 1'b1);
      // Second word queued while the first is on the wire
      axiWrite(SBR_IDX_BAUD, 32'h0000_0002);
      startMeasure();
      axiWrite(SBR_IDX_DATA, 32'h0000_00C3);
      axiWrite(SBR_IDX_DATA, 32'h0000_0096);
      waitIdle();
      check("queued edges", edges, 32'h20);
      check("queued select", ssRise, 32'h1);
      // Done half plus data setup half between words; no lead or gap
      check("queued spacing", maxGap, 32'h8);
      check("queued min spacing", minGap, 32'h4);
      check("queued slave", slvRx, 16'hC396);
      axiRead(SBR_IDX_DATA);
      check("queued rx", rd, 32'h0000_005A);
      axiWrite(SBR_IDX_STAT, 32'h0000_0080);
      // Sixteen-bit word
      axiWrite(SBR_IDX_CTRL, 32'h0000_0013);
      startMeasure();
      axiWrite(SBR_IDX_DATA, 32'h0000_BEEF);
      waitIdle();
      check("wide edges", edges, 32'h20);
      check("wide slave", slvRx, 16'hBEEF);
      check("wide bits", slvBits, 32'h10);
      axiRead(SBR_IDX_DATA);
      check("wide rx", rd, 32'h0000_A55A);
      // Phase one, two words with select held low between them
      slvPhase <= 1'b1;
      axiWrite(SBR_IDX_CTRL, 32'h0000_0007);
      startMeasure();
      axiWrite(SBR_IDX_DATA, 32'h0000_0081);
      axiWrite(SBR_IDX_DATA, 32'h0000_0042);
      waitIdle();
      check("phase one select", ssRise, 32'h1);
      check("phase one slave", slvRx, 16'h8142);
      axiRead(SBR_IDX_DATA);
      check("phase one rx", rd, 32'h0000_005A);
      stop_test();
   end
endmodule
